// [pkg/npic_pkg.sv]
// ****************************************
// Constants and helpers
// ****************************************
package npic_pkg;
	localparam int NUM_VEC = 14;
	// Register byte offsets
	localparam logic [11:0] OFF_PRIO0 = 12'h000;
	localparam logic [11:0] OFF_PRIO1 = 12'h004;
	localparam logic [11:0] OFF_PRIO2 = 12'h008;
	localparam logic [11:0] OFF_PRIO3 = 12'h00C;
	localparam logic [11:0] OFF_FLAGS = 12'h010;
	localparam logic [11:0] OFF_PEND = 12'h014;
	localparam logic [7:0] PRIO_RST = 8'hFF;
	localparam logic [3:0] PRIO3_FIXED = 4'hF;
	localparam int CC_I1_BIT = 5;
	localparam int CC_I0_BIT = 3;
	// Current-priority encodings
	localparam logic [1:0] I_LVL0 = 2'h2;
	localparam logic [1:0] I_LVL1 = 2'h1;
	localparam logic [1:0] I_LVL2 = 2'h0;
	localparam logic [1:0] I_LVL3 = 2'h3;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] VEC_TRAP = 16'hFFFC;
	localparam logic [15:0] VEC_BASE = 16'hFFFA;
	localparam logic [13:0] HALT_CAP = 14'h111E;
	localparam logic [13:0] PERIPH_MASK = 14'h3FE2;
	localparam logic [3:0] SVC_TRAP = 4'hE;
	localparam logic [1:0] STK_PC = 2'h0;
	localparam logic [1:0] STK_CC = 2'h3;
	localparam logic [1:0] STK_LAST = 2'h3;
	typedef enum logic [2:0] {S_RESET, S_IDLE, S_PUSH, S_VECTOR, S_POP} npic_state_e;
	typedef enum logic [1:0] {M_RUN, M_WAIT, M_HALT} npic_mode_e;

	// Encoded pair to numeric level 0..3
	function automatic logic [1:0] level_of(input logic [1:0] enc);
		unique case (enc)
			I_LVL0: level_of = 2'd0;
			I_LVL1: level_of = 2'd1;
			I_LVL2: level_of = 2'd2;
			default: level_of = 2'd3;
		endcase
	endfunction

	function automatic logic [15:0] vec_addr(input logic [3:0] idx);
		vec_addr = VEC_BASE - {11'h000, idx, 1'b0};
	endfunction
endpackage

// [hdl/npic_edge_latch.sv]
`timescale 1ns/1ps
module npic_edge_latch #(
	parameter int W = 1
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Source
	input wire logic [W-1:0] pins,
	input wire logic fall_sel,
	input wire logic set_in,
	input wire logic clr,
	// Latched request
	output logic pend
);
	logic [W-1:0] prev_reg;
	logic [W-1:0] edges;
	logic hit;
	logic primed_reg;

	assign edges = fall_sel ? (prev_reg & ~pins) : (~prev_reg & pins);
	// First cycle after reset ignores pin edges while priming the pin history
	assign hit = (primed_reg && (|edges)) || set_in;

	// ****************************************
	// Edge latch, set beats clear
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prev_reg <= '0;
			primed_reg <= 1'b0;
			pend <= 1'b0;
		end else begin
			prev_reg <= pins;
			primed_reg <= 1'b1;
			pend <= hit | (pend & ~clr);
		end
	end
endmodule // npic_edge_latch

// [hdl/npic_arbiter.sv]
`timescale 1ns/1ps
module npic_arbiter (
	// Requests and priorities
	input wire logic [13:0] pend,
	input wire logic [27:0] prio_flat,
	input wire logic [1:0] cur_enc,
	input wire logic halt_only,
	// Winner
	output logic win_valid,
	output logic [3:0] win_idx
);
	logic [13:0] cand;
	logic [2:0] best;
	logic [2:0] eff;

	assign cand = halt_only ? (pend & npic_pkg::HALT_CAP) : pend;

	// ****************************************
	// Highest level wins, lower index on ties
	// ****************************************
	always_comb begin
		best = 3'd0;
		eff = 3'd0;
		win_valid = 1'b0;
		win_idx = 4'h0;
		for (int i = npic_pkg::NUM_VEC - 1; i >= 0; i--) begin
			if (i == 0) begin
				eff = 3'd4; // [RULE_13]
			end else begin
				eff = {1'b0, npic_pkg::level_of(prio_flat[2*i +: 2])};
			end
			if (cand[i] && eff > {1'b0, npic_pkg::level_of(cur_enc)} && eff >= best) begin // [RULE_06] [RULE_11]
				best = eff;
				win_valid = 1'b1;
				win_idx = 4'(i);
			end
		end
	end
endmodule // npic_arbiter

// [hdl/npic_top.sv]
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// (RULE_01) Priority pair encodes levels 10,01,00,11
// (RULE_02) Finish instruction, stack PC X A CC
// (RULE_03) Maskable entry loads vector's stored priority
// (RULE_04) Vector fetched from top address table
// (RULE_05) Return pops registers restoring priority bits
// (RULE_06) Highest software level, then hardware order
// (RULE_07) Unserviced requests stay latched until highest
// (RULE_08) Reset and trap ignore mask, set level 3
// (RULE_09) Reset highest, starts at level 3
// (RULE_10) Trap serviced as top-level event
// (RULE_11) Maskable needs enable and strictly higher level
// (RULE_12) Emergency stop from pin edge or speed error
// (RULE_13) Top-level vectors ignore stored priority pairs
// (RULE_14) External edges latched, cleared on entry, ORed
// (RULE_15) Peripheral request needs flag and enable
// (RULE_16) Clear sequence drops the peripheral latch
// (RULE_17) Any wakes wait, halt-capable wakes halt
// (RULE_18) After halt, halt-capable request served first
// (RULE_19) Other top request served right after
// (RULE_20) Four priority bytes, top nibble reads ones
// (RULE_21) Level-0 pattern writes leave pair unchanged
// (RULE_22) Raised priority re-enters pending vector
// (RULE_23) Unmask 10, mask and trap 11, sleep 10
module npic_top (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Request sources
	input wire logic motor_emergency_stop_pin,
	input wire logic motor_emergency_stop_fall_sel,
	input wire logic speed_err,
	input wire logic [11:0] ext_pins,
	input wire logic [2:0] ext_fall_sel,
	input wire logic [13:0] periph_flag,
	input wire logic [13:0] periph_en,
	input wire logic [13:0] periph_clr,
	// Core instruction events
	input wire logic instr_done,
	input wire logic unmask_op,
	input wire logic mask_all_op,
	input wire logic wait_for_event_op,
	input wire logic halt_op,
	input wire logic trap_op,
	input wire logic handler_return_op,
	// Core stack handshake
	input wire logic push_ack,
	input wire logic pop_ack,
	input wire logic [7:0] pop_data,
	output logic push_req,
	output logic pop_req,
	output logic [1:0] stack_sel,
	// Vectoring and state
	output logic vector_load,
	output logic [15:0] vector_addr,
	output logic prio_high_bit,
	output logic prio_low_bit,
	output logic cpu_wake
);
	// ****************************************
	// Declarations
	// ****************************************
	npic_pkg::npic_state_e state_reg;
	npic_pkg::npic_mode_e mode_reg;
	logic [7:0] prio_reg [4];
	logic [7:0] prio_next [4];
	logic [1:0] cur_reg;
	logic [1:0] cur_next;
	logic [3:0] svc_reg;
	logic halt_exit_reg;
	logic trap_reg;
	logic [13:0] periph_reg;
	logic motor_emergency_stop_pend;
	logic [2:0] ext_pend;
	logic [13:0] pend;
	logic [27:0] prio_flat;
	logic win_valid;
	logic [3:0] win_idx;
	logic [2:0] ext_clr;
	logic motor_emergency_stop_clr;
	logic take;
	logic wake;
	logic in_idle;
	logic enter;
	logic svc_top;
	logic [1:0] svc_prio;
	logic acc;
	logic wr_fire;
	logic [3:0] prio_sel;
	logic hit;
	logic [31:0] rdata;
	logic [7:0] flags_rd;

	// Keep old pair wherever the level-0 pattern is written
	function automatic logic [7:0] prio_filter(input logic [7:0] old, input logic [7:0] wd);
		logic [7:0] r;
		r = wd;
		for (int p = 0; p < 4; p++) begin
			if (wd[2*p +: 2] == npic_pkg::I_LVL0) begin
				r[2*p +: 2] = old[2*p +: 2]; // [RULE_21]
			end
		end
		return r;
	endfunction

	// ****************************************
	// Request sources
	// ****************************************
	npic_edge_latch #(
		.W(1)
	) u_motor_emergency_stop (
		.pclk(pclk),
		.presetn(presetn),
		.pins(motor_emergency_stop_pin),
		.fall_sel(motor_emergency_stop_fall_sel),
		.set_in(speed_err), // [RULE_12]
		.clr(motor_emergency_stop_clr),
		.pend(motor_emergency_stop_pend)
	);

	for (genvar g = 0; g < 3; g++) begin : g_ext
		npic_edge_latch #(
			.W(4)
		) u_ext (
			.pclk(pclk),
			.presetn(presetn),
			.pins(ext_pins[4*g +: 4]), // [RULE_14]
			.fall_sel(ext_fall_sel[g]),
			.set_in(1'b0),
			.clr(ext_clr[g]),
			.pend(ext_pend[g])
		);
	end

	assign in_idle = (state_reg == npic_pkg::S_IDLE);
	assign enter = (state_reg == npic_pkg::S_VECTOR);
	// Edge latches drop as their handler is entered
	assign motor_emergency_stop_clr = enter && svc_reg == 4'h0; // [RULE_14]
	assign ext_clr[0] = enter && svc_reg == 4'h2; // [RULE_14]
	assign ext_clr[1] = enter && svc_reg == 4'h3; // [RULE_14]
	assign ext_clr[2] = enter && svc_reg == 4'h4; // [RULE_14]
	// Requests stay latched until served or cleared
	assign pend = {periph_reg[13:5], ext_pend, periph_reg[1], motor_emergency_stop_pend}; // [RULE_07]
	assign prio_flat = {prio_reg[3][3:0], prio_reg[2], prio_reg[1], prio_reg[0]};

	npic_arbiter u_arb (
		.pend(pend),
		.prio_flat(prio_flat),
		.cur_enc(cur_reg),
		.halt_only(mode_reg == npic_pkg::M_HALT || halt_exit_reg), // [RULE_18]
		.win_valid(win_valid),
		.win_idx(win_idx)
	);

	// ****************************************
	// Sequencing decisions
	// ****************************************
	// Entries only at an instruction boundary
	assign take = in_idle && mode_reg == npic_pkg::M_RUN && instr_done
		&& (trap_reg || win_valid); // [RULE_02]
	assign wake = mode_reg != npic_pkg::M_RUN && win_valid; // [RULE_17]
	assign svc_top = svc_reg == npic_pkg::SVC_TRAP || svc_reg == 4'h0; // [RULE_13]
	assign svc_prio = prio_flat[{svc_reg, 1'b0} +: 2];

	always_comb begin
		cur_next = cur_reg;
		if (enter) begin
			cur_next = svc_top ? npic_pkg::I_LVL3 : svc_prio; // [RULE_03] [RULE_08] [RULE_10]
		end else if (state_reg == npic_pkg::S_POP && pop_ack && stack_sel == npic_pkg::STK_CC) begin
			cur_next = {pop_data[npic_pkg::CC_I1_BIT], pop_data[npic_pkg::CC_I0_BIT]}; // [RULE_05]
		end else if (in_idle && (unmask_op || wait_for_event_op || halt_op)) begin
			cur_next = npic_pkg::I_LVL0; // [RULE_23] [RULE_01]
		end else if (in_idle && mask_all_op) begin
			// Trap level is set at its entry, after stacking
			cur_next = npic_pkg::I_LVL3; // [RULE_23]
		end
	end

	// ****************************************
	// APB decode
	// ****************************************
	assign acc = psel && penable;
	assign wr_fire = acc && pready && pwrite;
	assign prio_sel[0] = paddr == npic_pkg::OFF_PRIO0;
	assign prio_sel[1] = paddr == npic_pkg::OFF_PRIO1;
	assign prio_sel[2] = paddr == npic_pkg::OFF_PRIO2;
	assign prio_sel[3] = paddr == npic_pkg::OFF_PRIO3;
	assign hit = (|prio_sel) || paddr == npic_pkg::OFF_FLAGS || paddr == npic_pkg::OFF_PEND;
	assign flags_rd = {2'b00, cur_reg[1], 1'b0, cur_reg[0], 3'b000};
	assign rdata = prio_sel[0] ? {24'h000000, prio_reg[0]} :
		prio_sel[1] ? {24'h000000, prio_reg[1]} :
		prio_sel[2] ? {24'h000000, prio_reg[2]} :
		prio_sel[3] ? {24'h000000, prio_reg[3]} :
		paddr == npic_pkg::OFF_FLAGS ? {24'h000000, flags_rd} :
		paddr == npic_pkg::OFF_PEND ? {18'h00000, pend} : 32'h00000000;

	always_comb begin
		for (int r = 0; r < 4; r++) begin
			prio_next[r] = prio_reg[r];
			if (wr_fire && prio_sel[r]) begin
				prio_next[r] = prio_filter(prio_reg[r], pwdata[7:0]); // [RULE_22]
			end
		end
		prio_next[3][7:4] = npic_pkg::PRIO3_FIXED; // [RULE_20]
	end

	// ****************************************
	// APB response and priority registers
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= acc && !pready;
			pslverr <= acc && !pready && !hit;
			if (acc && !pready) begin
				prdata <= rdata;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int r = 0; r < 4; r++) begin
				prio_reg[r] <= npic_pkg::PRIO_RST; // [RULE_20]
			end
		end else begin
			for (int r = 0; r < 4; r++) begin
				prio_reg[r] <= prio_next[r];
			end
		end
	end

	// ****************************************
	// Peripheral latches and trap
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_reg <= 14'h0000;
			trap_reg <= 1'b0;
		end else begin
			periph_reg <= ((periph_reg & ~periph_clr) | (periph_flag & periph_en))
				& npic_pkg::PERIPH_MASK; // [RULE_15] [RULE_16]
			if (in_idle && trap_op) begin
				trap_reg <= 1'b1; // [RULE_10]
			end else if (enter && svc_reg == npic_pkg::SVC_TRAP) begin
				trap_reg <= 1'b0;
			end
		end
	end

	// ****************************************
	// Low-power modes
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= npic_pkg::M_RUN;
			halt_exit_reg <= 1'b0;
			cpu_wake <= 1'b0;
		end else begin
			cpu_wake <= wake; // [RULE_17]
			if (wake) begin
				mode_reg <= npic_pkg::M_RUN;
				if (mode_reg == npic_pkg::M_HALT) begin
					halt_exit_reg <= 1'b1; // [RULE_18]
				end
			end else if (in_idle && halt_op) begin
				mode_reg <= npic_pkg::M_HALT;
			end else if (in_idle && wait_for_event_op) begin
				mode_reg <= npic_pkg::M_WAIT;
			end
			if (enter) begin
				halt_exit_reg <= 1'b0; // [RULE_19]
			end
		end
	end

	// ****************************************
	// Entry and return sequencer
	// ****************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= npic_pkg::S_RESET;
			cur_reg <= npic_pkg::I_LVL3; // [RULE_09]
			svc_reg <= 4'h0;
			push_req <= 1'b0;
			pop_req <= 1'b0;
			stack_sel <= npic_pkg::STK_PC;
			vector_load <= 1'b0;
			vector_addr <= npic_pkg::VEC_RESET;
		end else begin
			cur_reg <= cur_next;
			vector_load <= 1'b0;
			unique case (state_reg)
				npic_pkg::S_RESET: begin
					// Reset vectors without stacking
					vector_load <= 1'b1; // [RULE_08] [RULE_09]
					vector_addr <= npic_pkg::VEC_RESET;
					state_reg <= npic_pkg::S_IDLE;
				end
				npic_pkg::S_IDLE: begin
					if (take) begin
						svc_reg <= trap_reg ? npic_pkg::SVC_TRAP : win_idx; // [RULE_06]
						push_req <= 1'b1; // [RULE_02]
						stack_sel <= npic_pkg::STK_PC;
						state_reg <= npic_pkg::S_PUSH;
					end else if (handler_return_op) begin
						pop_req <= 1'b1; // [RULE_05]
						stack_sel <= npic_pkg::STK_CC;
						state_reg <= npic_pkg::S_POP;
					end
				end
				npic_pkg::S_PUSH: begin
					if (push_ack) begin
						if (stack_sel == npic_pkg::STK_LAST) begin
							push_req <= 1'b0;
							state_reg <= npic_pkg::S_VECTOR;
						end else begin
							stack_sel <= stack_sel + 2'd1; // [RULE_02]
						end
					end
				end
				npic_pkg::S_VECTOR: begin
					vector_load <= 1'b1; // [RULE_04]
					vector_addr <= (svc_reg == npic_pkg::SVC_TRAP) ? npic_pkg::VEC_TRAP
						: npic_pkg::vec_addr(svc_reg);
					state_reg <= npic_pkg::S_IDLE;
				end
				npic_pkg::S_POP: begin
					if (pop_ack) begin
						if (stack_sel == npic_pkg::STK_PC) begin
							pop_req <= 1'b0;
							state_reg <= npic_pkg::S_IDLE;
						end else begin
							stack_sel <= stack_sel - 2'd1; // [RULE_05]
						end
					end
				end
				default: state_reg <= npic_pkg::S_IDLE;
			endcase
		end
	end

	assign prio_high_bit = cur_reg[1];
	assign prio_low_bit = cur_reg[0];
endmodule // npic_top

// [tb/npic_properties.sv]
`timescale 1ns/1ps
// ****
// Checker
// ****
module npic_checker (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Core events
	input wire logic unmask_op,
	input wire logic mask_all_op,
	input wire logic trap_op,
	// Stack and vector
	input wire logic push_req,
	input wire logic pop_req,
	input wire logic pop_ack,
	input wire logic [7:0] pop_data,
	input wire logic [1:0] stack_sel,
	input wire logic vector_load,
	input wire logic [15:0] vector_addr,
	input wire logic prio_high_bit,
	input wire logic prio_low_bit
);
	logic [7:0] pd_q;
	wire [1:0] cur = {prio_high_bit, prio_low_bit};
	always_ff @(posedge pclk) pd_q <= pop_data;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	chk_reset_vector: assert property ($rose(presetn) |=> vector_load && vector_addr == 16'hFFFE && cur == 2'h3) else $error("reset vector wrong");
	chk_unmask_level: assert property (!push_req && !pop_req && !$past(push_req) && !vector_load && unmask_op |=> cur == 2'h2) else $error("unmask level wrong");
	chk_mask_level: assert property (!push_req && !pop_req && !$past(push_req) && !vector_load && mask_all_op |=> cur == 2'h3) else $error("mask level wrong");
	chk_trap_entry: assert property (!push_req && !pop_req && !$past(push_req) && !vector_load && trap_op |-> ##[1:200] vector_load && vector_addr == 16'hFFFC && cur == 2'h3) else $error("trap not vectored");
	chk_push_start: assert property ($rose(push_req) |-> stack_sel == 2'h0) else $error("push order wrong");
	chk_push_vector: assert property ($fell(push_req) |=> vector_load) else $error("no vector after push");
	chk_stack_first: assert property (vector_load && vector_addr != 16'hFFFE |-> $past(push_req, 2)) else $error("vector without stacking");
	chk_vector_table: assert property (vector_load |-> vector_addr[15:5] == 11'h7FF && !vector_addr[0]) else $error("vector outside table");
	chk_top_level: assert property (vector_load && vector_addr >= 16'hFFFA |-> cur == 2'h3) else $error("top level not 3");
	chk_pop_start: assert property ($rose(pop_req) |-> stack_sel == 2'h3) else $error("pop order wrong");
	chk_pop_restore: assert property (pop_req && pop_ack && stack_sel == 2'h3 |=> cur == {pd_q[5], pd_q[3]}) else $error("level not restored");
	cover property (vector_load && vector_addr == 16'hFFFC);
	cover property (pop_req && pop_ack);
	cover property ($rose(push_req));
endmodule // npic_checker
bind npic_top npic_checker u_chk (.pclk, .presetn, .unmask_op, .mask_all_op, .trap_op, .push_req,
	.pop_req, .pop_ack, .pop_data, .stack_sel, .vector_load, .vector_addr, .prio_high_bit,
	.prio_low_bit);

// [tb/npic_core_model.sv]
`timescale 1ns/1ps
// ****
// Core stack partner
// ****
module npic_core_model (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Stack handshake
	input wire logic push_req,
	input wire logic pop_req,
	input wire logic [1:0] stack_sel,
	input wire logic prio_high_bit,
	input wire logic prio_low_bit,
	input wire logic slow,
	output logic push_ack,
	output logic pop_ack,
	output logic [7:0] pop_data
);
	logic [1:0] stk [8];
	logic [2:0] sp;
	wire [1:0] top = stk[sp - 3'd1];
	wire [7:0] cc_w = {2'h3, top[1], 1'b0, top[0], 3'h0};
	// Flags word only while asked for
	assign pop_data = (pop_req && stack_sel == 2'h3) ? cc_w : ~cc_w;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			push_ack <= 1'b0;
			pop_ack <= 1'b0;
			sp <= 3'h0;
		end else begin
			push_ack <= push_req && !push_ack && !slow;
			pop_ack <= pop_req && !pop_ack && !slow;
			if (push_req && push_ack && stack_sel == 2'h3) begin
				stk[sp] <= {prio_high_bit, prio_low_bit};
				sp <= sp + 3'd1;
			end
			if (pop_req && pop_ack && stack_sel == 2'h3) sp <= sp - 3'd1;
		end
	end
endmodule // npic_core_model

// [tb/nested_priority_interrupt_ctrl_tb.sv]
`timescale 1ns/1ps
// ****
// Bench
// ****
module nested_priority_interrupt_ctrl_tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, motor_emergency_stop_pin, motor_emergency_stop_fall_sel, speed_err;
	logic instr_done, slow, push_ack, pop_ack, push_req, pop_req, vector_load, cpu_wake, err_q;
	logic prio_high_bit, prio_low_bit;
	logic [11:0] paddr, ext_pins;
	logic [31:0] pwdata, prdata, rd_q, r, rb, seed;
	logic [13:0] periph_flag, periph_en, periph_clr;
	logic [7:0] pop_data, exp;
	logic [5:0] ops;
	logic [2:0] ext_fall_sel;
	logic [1:0] stack_sel;
	logic [15:0] vector_addr;
	wire unmask_op, mask_all_op, wait_for_event_op, halt_op, trap_op, handler_return_op;
	int n_fail, checked, cyc;
	assign {handler_return_op, trap_op, halt_op, wait_for_event_op, mask_all_op, unmask_op} = ops;
	npic_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .motor_emergency_stop_pin, .motor_emergency_stop_fall_sel, .speed_err, .ext_pins, .ext_fall_sel, .periph_flag,
		.periph_en, .periph_clr, .instr_done, .unmask_op, .mask_all_op, .wait_for_event_op,
		.halt_op, .trap_op, .handler_return_op, .push_ack, .pop_ack, .pop_data, .push_req,
		.pop_req, .stack_sel, .vector_load, .vector_addr, .prio_high_bit, .prio_low_bit,
		.cpu_wake);
	npic_core_model core (.pclk, .presetn, .push_req, .pop_req, .stack_sel, .prio_high_bit,
		.prio_low_bit, .slow, .push_ack, .pop_ack, .pop_data);
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Pairs written as level 0 keep the old value
	function automatic logic [7:0] merge(input logic [7:0] o, input logic [7:0] n);
		for (int i = 0; i < 8; i += 2)
			if (n[i+:2] != 2'h2) o[i+:2] = n[i+:2];
		return o;
	endfunction
	task automatic tally_and_finish();
		$display("checked=%0d n_fail=%0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		checked++;
		if (g !== x) begin
			n_fail++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd_q = prdata;
		err_q = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rd_q, x);
	endtask
	task automatic op(input logic [5:0] m);
		@(posedge pclk);
		ops <= m;
		@(posedge pclk);
		ops <= 6'h00;
		@(posedge pclk);
		for (int i = 0; i < 60 && pop_req === 1'b1; i++) @(posedge pclk);
	endtask
	task automatic wait_vec(input logic [15:0] a, input logic [1:0] p);
		for (int i = 0; i < 200 && vector_load !== 1'b1; i++) @(posedge pclk);
		chk({14'h0, vector_addr, prio_high_bit, prio_low_bit}, {14'h0, a, p});
		@(posedge pclk);
	endtask
	task automatic quiet(input int n);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge pclk);
			c += vector_load | cpu_wake;
		end
		chk(c, 0);
	endtask
	task automatic woke();
		for (int i = 0; i < 100 && cpu_wake !== 1'b1; i++) @(posedge pclk);
		chk(cpu_wake, 1);
	endtask
	task automatic clr(input logic [13:0] m);
		periph_flag <= periph_flag & ~m;
		periph_clr <= m;
		@(posedge pclk);
		periph_clr <= 14'h0;
	endtask
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		rb = xs();
		instr_done <= rb[0] | rb[1];
		slow <= rb[2] & rb[3];
		cyc++;
		if (cyc > 20000) begin
			n_fail++;
			tally_and_finish();
		end
	end
	initial begin
		seed = 32'd99472;
		{presetn, psel, penable, pwrite, motor_emergency_stop_pin, motor_emergency_stop_fall_sel, speed_err} = 7'h0;
		{instr_done, slow, ops, ext_fall_sel, paddr, ext_pins, pwdata} = 0;
		{periph_flag, periph_en, periph_clr} = 42'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		wait_vec(16'hFFFE, 2'h3);
		for (int i = 0; i < 4; i++) rd(12'(i * 4), 32'hFF);
		rd(12'h010, 32'h28);
		apb(1'b0, 12'h020, 32'h0);
		chk(err_q, 1);
		apb(1'b1, 12'h000, 32'hCF);
		apb(1'b1, 12'h000, 32'h64);
		rd(12'h000, 32'h44);
		apb(1'b1, 12'h00C, 32'h0);
		rd(12'h00C, 32'hF0);
		exp = 8'hFF;
		repeat (8) begin
			r = xs();
			exp = merge(exp, r[7:0]);
			apb(1'b1, 12'h004, {24'h0, r[7:0]});
			rd(12'h004, {24'h0, exp});
		end
		apb(1'b1, 12'h000, 32'hDF);
		apb(1'b1, 12'h004, 32'hC7);
		op(6'h04);
		rd(12'h010, 32'h20);
		periph_en <= 14'h0060;
		periph_flag <= 14'h0060;
		woke();
		wait_vec(16'hFFEE, 2'h0);
		quiet(30);
		clr(14'h0040);
		op(6'h20);
		wait_vec(16'hFFF0, 2'h1);
		op(6'h10);
		wait_vec(16'hFFFC, 2'h3);
		op(6'h20);
		rd(12'h010, 32'h08);
		quiet(20);
		clr(14'h0020);
		op(6'h20);
		rd(12'h010, 32'h20);
		quiet(20);
		op(6'h02);
		motor_emergency_stop_pin <= 1'b1;
		wait_vec(16'hFFFA, 2'h3);
		op(6'h20);
		quiet(20);
		apb(1'b1, 12'h004, 32'hC3);
		op(6'h08);
		periph_flag <= 14'h0020;
		quiet(20);
		ext_pins <= 12'h001;
		woke();
		wait_vec(16'hFFF6, 2'h1);
		wait_vec(16'hFFF0, 2'h0);
		apb(1'b1, 12'h004, 32'hCF);
		wait_vec(16'hFFF0, 2'h3);
		tally_and_finish();
	end
endmodule // nested_priority_interrupt_ctrl_tb
